// [rtl/adcfg_device.sv]
// adcfg_device: converter end of the link; setup registers, clock tree,
// control-pin lockout, span selection and output code formatting.
// assumes the host drives the link on clk_sys and keeps its own rules.
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/1ps
module adcfg_device
  import adcfg_pkg::*;
#(
  parameter int LOCK_CYC = LOCK_CYCLES // lockout length in clk_sys
) (
  input wire logic clk_sys,
  input wire logic rst,
  adcfg_if.dev lnk,
  input wire logic sat_event, // modulator saturated this cycle
  input wire logic conv_stb, // raw result valid
  input wire logic signed [17:0] conv_raw, // 2^16 = selected full scale
  output logic core_clk, // core clock level
  output logic mod_clk, // modulator clock level
  output logic ref_bypass, // reference precharge buffer bypassed
  output logic span_2x, // effective span is double reference
  output logic [15:0] code, // formatted output code
  output logic code_valid, // one-cycle pulse with code
  output logic start_ok, // accepted start pin rise, pulse
  output logic reset_ok, // accepted reset pin rise, pulse
  output logic lockout // control pins currently ignored
);
  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (LOCK_CYC < 1 || LOCK_CYC > 65535) begin : g_bad_lock
    $error("adcfg_device: LOCK_CYC out of range");
  end

  // ----------------------------------------------------------------
  // code formatting
  // ----------------------------------------------------------------
  // extended range shrinks the code by 4/5 so 1.25x scale hits the rails
  function automatic logic [15:0] fmt_code(
    input logic signed [17:0] raw,
    input logic ext,
    input logic unip
  );
    logic signed [35:0] prod; // raw times 0.8 in Q16
    logic signed [17:0] s; // value after range scaling
    logic signed [17:0] h; // bipolar half scale
    prod = raw * $signed(18'h0CCCD);
    s = ext ? prod[33:16] : raw;
    h = s >>> 1;
    fmt_code = 16'h0000;
    if (unip) begin
      // unipolar: negatives clip to zero, full 16 bits used
      if (s < 0) fmt_code = 16'h0000;
      else if (s > 18'sh0FFFF) fmt_code = 16'hFFFF;
      else fmt_code = s[15:0];
    end else begin
      // bipolar: 15 bits each sign, two's complement
      if (h > 18'sh07FFF) fmt_code = 16'h7FFF;
      else if (h < -18'sh08000) fmt_code = 16'h8000;
      else fmt_code = h[15:0];
    end
  endfunction : fmt_code

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] setup_reg_a_r; // span, reference range, precharge
  logic [7:0] setup_reg_b_r; // extended range and clock control
  logic [7:0] setup_reg_d_r; // polarity
  logic sat_r; // sticky saturation flag
  logic [7:0] rdata_r; // read data for the cycle after rd_stb
  logic [15:0] lock_cnt_r; // remaining lockout cycles
  logic ext_q_r; // last ext_clk level
  logic start_q_r; // last start pin level
  logic reset_q_r; // last reset pin level

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic wr_a, wr_b, wr_d, rd_st; // strobes per register
  assign wr_a = lnk.wr_stb && lnk.addr == ADR_SETUP_A;
  assign wr_b = lnk.wr_stb && lnk.addr == ADR_SETUP_B;
  assign wr_d = lnk.wr_stb && lnk.addr == ADR_SETUP_D;
  assign rd_st = lnk.rd_stb && lnk.addr == ADR_STATUS;

  // named setting bits
  logic span_sel, ref_high, prech_en; // setup_reg_a fields
  logic ext_rng, clk_src, prediv, hspeed; // setup_reg_b fields
  logic unipolar; // setup_reg_d field
  assign span_sel = setup_reg_a_r[A_SPAN];
  assign ref_high = setup_reg_a_r[A_REF];
  assign prech_en = setup_reg_a_r[A_PRECH];
  assign ext_rng = setup_reg_b_r[B_EXTRNG];
  assign clk_src = setup_reg_b_r[B_CLKSRC];
  assign prediv = setup_reg_b_r[B_PREDIV];
  assign hspeed = setup_reg_b_r[B_HSPEED];
  assign unipolar = setup_reg_d_r[D_POL];

  // a write that flips the source bit starts the lockout
  logic src_change;
  assign src_change = wr_b && (lnk.wdata[B_CLKSRC] != clk_src);

  // read mux, status shows sticky flag and lockout
  logic [7:0] rd_mux;
  logic [7:0] status_v;
  assign status_v = {6'h00, lock_cnt_r != 16'h0000, sat_r};
  assign rd_mux = (lnk.addr == ADR_SETUP_A) ? setup_reg_a_r :
                  (lnk.addr == ADR_SETUP_B) ? setup_reg_b_r :
                  (lnk.addr == ADR_SETUP_D) ? setup_reg_d_r : status_v;

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  // reset brings the internal oscillator back
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      setup_reg_a_r <= RST_SETUP_A;
      setup_reg_b_r <= RST_SETUP_B;
      setup_reg_d_r <= RST_SETUP_D;
    end else begin
      if (wr_a) setup_reg_a_r <= lnk.wdata;
      if (wr_b) setup_reg_b_r <= lnk.wdata;
      if (wr_d) setup_reg_d_r <= lnk.wdata;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= lnk.rd_stb ? rd_mux : 8'h00;
    end
  end
  assign lnk.rdata = rdata_r;

  // sticky flag, a new event wins over the clearing read
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sat_r <= 1'b0;
    end else begin
      sat_r <= sat_event | (sat_r & ~rd_st);
    end
  end

  // ----------------------------------------------------------------
  // clock tree
  // ----------------------------------------------------------------
  logic osc_tick; // internal oscillator tick
  logic ext_tick; // external clock after predivide
  logic ext_rise; // external clock rising edge
  logic core_tick; // selected core clock event
  assign ext_rise = lnk.ext_clk & ~ext_q_r;

  // oscillator runs eight times slower in low speed
  adcfg_tick_div #(.W(4)) u_osc (
    .clk_sys(clk_sys),
    .rst(rst),
    .en(1'b1),
    .div(hspeed ? OSC_DIV_HS : OSC_DIV_LS),
    .tick(osc_tick)
  );

  // divide-by-eight on the external pin when asked
  adcfg_tick_div #(.W(4)) u_prediv (
    .clk_sys(clk_sys),
    .rst(rst),
    .en(ext_rise),
    .div(prediv ? PREDIV_ON : PREDIV_OFF),
    .tick(ext_tick)
  );

  // the source switch relies on the host keeping the pin alive
  assign core_tick = clk_src ? ext_tick : osc_tick;

  // core clock toggles on each tick, modulator on each core rise
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ext_q_r <= 1'b0;
      core_clk <= 1'b0;
      mod_clk <= 1'b0;
    end else begin
      ext_q_r <= lnk.ext_clk;
      if (core_tick) core_clk <= ~core_clk;
      if (core_tick && !core_clk) mod_clk <= ~mod_clk;
    end
  end

  // sample phase is mod_clk high; its second half has core_clk low
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ref_bypass <= 1'b0;
    end else begin
      ref_bypass <= prech_en & mod_clk & ~core_clk;
    end
  end

  // ----------------------------------------------------------------
  // control pin lockout
  // ----------------------------------------------------------------
  // counted on clk_sys so a stopped external clock cannot stretch it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lock_cnt_r <= 16'h0000;
    end else if (src_change) begin
      lock_cnt_r <= 16'(LOCK_CYC);
    end else if (lock_cnt_r != 16'h0000) begin
      lock_cnt_r <= lock_cnt_r - 16'h0001;
    end
  end

  // pin rises inside the lockout are dropped, not deferred
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      start_q_r <= 1'b0;
      reset_q_r <= 1'b0;
      start_ok <= 1'b0;
      reset_ok <= 1'b0;
      lockout <= 1'b0;
    end else begin
      start_q_r <= lnk.start_pin;
      reset_q_r <= lnk.reset_pin;
      lockout <= src_change | (lock_cnt_r > 16'h0001);
      start_ok <= lnk.start_pin & ~start_q_r &
                  (lock_cnt_r == 16'h0000);
      reset_ok <= lnk.reset_pin & ~reset_q_r &
                  (lock_cnt_r == 16'h0000);
    end
  end

  // ----------------------------------------------------------------
  // span and output code
  // ----------------------------------------------------------------
  // high reference range overrides the double span
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      span_2x <= 1'b0;
      code <= 16'h0000;
      code_valid <= 1'b0;
    end else begin
      span_2x <= span_sel & ~ref_high;
      code_valid <= conv_stb;
      if (conv_stb) code <= fmt_code(conv_raw, ext_rng, unipolar);
    end
  end
endmodule : adcfg_device

// [rtl/adcfg_pkg.sv]
// adcfg_pkg: shared constants of the converter clock and range setup.
// assumes one system clock, clk_sys, at 40 MHz on both ends.
package adcfg_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_SYS_KHZ = 40000; // system clock rate
  localparam int LOCK_TIME_US = 150; // pin lockout after source change
  // least time, rounded up to whole cycles
  localparam int LOCK_CYCLES = (LOCK_TIME_US * CLK_SYS_KHZ + 999) / 1000;
  localparam int EXT_HALF = 2; // host ext clock half period, cycles
  localparam int EXT_GUARD_PER = 4; // ext periods kept around a switch
  localparam int EXT_GUARD = EXT_GUARD_PER * 2 * EXT_HALF;
  // oscillator model: clk_sys cycles per core tick, low speed eight times slower
  localparam logic [3:0] OSC_DIV_HS = 4'h1;
  localparam logic [3:0] OSC_DIV_LS = 4'h8;
  localparam logic [3:0] PREDIV_ON = 4'h8; // external divide-by-eight
  localparam logic [3:0] PREDIV_OFF = 4'h1;
  // ----------------------------------------------------------------
  // device register map (link addresses)
  // ----------------------------------------------------------------
  localparam logic [1:0] ADR_SETUP_A = 2'h0;
  localparam logic [1:0] ADR_SETUP_B = 2'h1;
  localparam logic [1:0] ADR_STATUS = 2'h2;
  localparam logic [1:0] ADR_SETUP_D = 2'h3;
  // setup_reg_a fields
  localparam int A_SPAN = 0; // input_span_select
  localparam int A_REF = 1; // reference_span_select, 1 = high range
  localparam int A_PRECH = 2; // reference precharge buffer enable
  // setup_reg_b fields
  localparam int B_EXTRNG = 0; // extended range
  localparam int B_CLKSRC = 1; // 1 = external clock
  localparam int B_PREDIV = 2; // external clock divide by eight
  localparam int B_HSPEED = 3; // 1 = high-speed mode
  // setup_reg_d fields
  localparam int D_POL = 0; // polarity_mode_select, 1 = unipolar
  // status fields
  localparam int S_SAT = 0; // modulator_saturation_flag
  localparam int S_LOCK = 1; // control pins locked out
  localparam logic [7:0] RST_SETUP_A = 8'h00;
  localparam logic [7:0] RST_SETUP_B = 8'h08;
  localparam logic [7:0] RST_SETUP_D = 8'h00;
  // ----------------------------------------------------------------
  // host software port
  // ----------------------------------------------------------------
  localparam logic [2:0] H_CMD = 3'h0; // [12] read, [9:8] adr, [7:0] data
  localparam logic [2:0] H_STATUS = 3'h1; // sticky events, read clears
  localparam logic [2:0] H_MASK = 3'h2;
  localparam logic [2:0] H_VREF = 3'h3; // applied reference in mV
  localparam logic [2:0] H_CLKCTL = 3'h4; // [0] run external clock
  localparam logic [2:0] H_RDDATA = 3'h5;
  localparam logic [2:0] H_PINS = 3'h6; // [0] start, [1] reset
  localparam int CMD_RD = 12;
  localparam int EV_WDONE = 0;
  localparam int EV_RDONE = 1;
  localparam logic [15:0] VREF_LOW_MAX_MV = 16'h0ABE; // 2750 mV
endpackage : adcfg_pkg

// [rtl/adcfg_if.sv]
// adcfg_if: link between the host controller and the converter setup.
// assumes both ends run on the same clk_sys; no clocking block.
`timescale 1ns/1ps
interface adcfg_if;
  logic wr_stb; // one-cycle register write
  logic rd_stb; // one-cycle register read
  logic [1:0] addr; // register address
  logic [7:0] wdata; // write data
  logic [7:0] rdata; // read data, cycle after rd_stb
  logic ext_clk; // external clock pin level
  logic start_pin; // start control pin level
  logic reset_pin; // reset control pin level
  modport dev (
    input wr_stb, rd_stb, addr, wdata, ext_clk, start_pin, reset_pin,
    output rdata
  );
  modport host (
    output wr_stb, rd_stb, addr, wdata, ext_clk, start_pin, reset_pin,
    input rdata
  );
endinterface : adcfg_if

// [rtl/adcfg_tick_div.sv]
// adcfg_tick_div: counts enable pulses, emits a tick every div of them.
// assumes div is held steady by the caller; div of 0 acts as 1.
`timescale 1ns/1ps
module adcfg_tick_div #(
  parameter int W = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic en,
  input wire logic [W-1:0] div,
  output logic tick
);
  logic [W-1:0] cnt_r; // pulses seen in this period
  logic last; // this pulse closes the period
  assign last = (cnt_r + W'(1) >= div);
  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
      tick <= 1'b0;
    end else begin
      tick <= en & last;
      if (en) begin
        cnt_r <= last ? '0 : cnt_r + W'(1);
      end
    end
  end
endmodule : adcfg_tick_div

// [rtl/adcfg_host.sv]
// adcfg_host: controller end; turns software orders into link accesses,
// runs the external clock and guards clock source switches.
// assumes the device samples the link on the same clk_sys.
`timescale 1ns/1ps
module adcfg_host
  import adcfg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  adcfg_if.host lnk,
  input wire logic [2:0] sw_addr, // software register address
  input wire logic [15:0] sw_wdata, // software write data
  input wire logic sw_wr, // one-cycle write strobe
  input wire logic sw_rd, // one-cycle read strobe
  output logic [15:0] sw_rdata, // read data, cycle after sw_rd
  output logic irq // level, unmasked event pending
);
  typedef enum logic [1:0] {ADCFG_IDLE, ADCFG_LEAD, ADCFG_WAIT} adcfg_st_e;
  adcfg_st_e st_r; // sequencer state
  logic [15:0] cmd_r; // pending command
  logic [15:0] vref_r; // applied reference, mV
  logic [1:0] stat_r, mask_r; // sticky events and mask
  logic clkrun_r; // software asks for the external clock
  logic [1:0] pins_r; // start and reset pin levels
  logic [7:0] rddata_r; // last link read result
  logic src_r; // source bit last written to the device
  logic [7:0] guard_r; // cycles of forced clock around a switch
  logic [3:0] half_r; // ext clock half-period counter
  logic ext_r; // ext clock level
  logic wr_r, rd_r; // link strobes
  logic rd_wait_r; // link read data due this cycle
  logic [1:0] adr_r; // link address
  logic [7:0] wd_r; // link write data

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic cmd_go, sel_ext, sel_int, rd_stat; // command kinds
  logic [7:0] wd_fix; // data with reference range bit applied
  assign cmd_go = sw_wr && sw_addr == H_CMD && st_r == ADCFG_IDLE;
  assign sel_ext = !sw_wdata[CMD_RD] && sw_wdata[9:8] == ADR_SETUP_B &&
                   sw_wdata[B_CLKSRC] && !src_r;
  assign sel_int = !cmd_r[CMD_RD] && cmd_r[9:8] == ADR_SETUP_B &&
                   !cmd_r[B_CLKSRC] && src_r;
  assign rd_stat = sw_rd && sw_addr == H_STATUS;
  // low reference range where it covers the reference
  assign wd_fix = (cmd_r[9:8] == ADR_SETUP_A) ?
    {cmd_r[7:2], vref_r > VREF_LOW_MAX_MV, cmd_r[0]} : cmd_r[7:0];

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      vref_r <= 16'h09C4;
      mask_r <= 2'h0;
      clkrun_r <= 1'b0;
      pins_r <= 2'h0;
    end else if (sw_wr) begin
      if (sw_addr == H_VREF) vref_r <= sw_wdata;
      if (sw_addr == H_MASK) mask_r <= sw_wdata[1:0];
      if (sw_addr == H_CLKCTL) clkrun_r <= sw_wdata[0];
      if (sw_addr == H_PINS) pins_r <= sw_wdata[1:0];
    end
  end

  // read mux, one cycle late; events win over the clearing read
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sw_rdata <= 16'h0000;
      stat_r <= 2'h0;
      irq <= 1'b0;
    end else begin
      unique case (sw_addr)
        H_STATUS: sw_rdata <= {14'h0000, stat_r};
        H_MASK: sw_rdata <= {14'h0000, mask_r};
        H_VREF: sw_rdata <= vref_r;
        H_CLKCTL: sw_rdata <= {15'h0000, clkrun_r};
        H_RDDATA: sw_rdata <= {8'h00, rddata_r};
        H_PINS: sw_rdata <= {14'h0000, pins_r};
        default: sw_rdata <= {3'h0, st_r != ADCFG_IDLE, cmd_r[11:0]};
      endcase
      if (!sw_rd) sw_rdata <= 16'h0000;
      stat_r <= (stat_r & ~{2{rd_stat}}) | {rd_wait_r, wr_r};
      irq <= |(((stat_r & ~{2{rd_stat}}) | {rd_wait_r, wr_r}) & mask_r);
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // selecting the external clock waits for it to run first
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r <= ADCFG_IDLE;
      cmd_r <= 16'h0000;
      guard_r <= 8'h00;
      src_r <= 1'b0;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      rd_wait_r <= 1'b0;
      adr_r <= 2'h0;
      wd_r <= 8'h00;
      rddata_r <= 8'h00;
    end else begin
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      rd_wait_r <= rd_r;
      if (rd_wait_r) rddata_r <= lnk.rdata;
      if (guard_r != 8'h00) guard_r <= guard_r - 8'h01;
      unique case (st_r)
        ADCFG_IDLE: if (cmd_go) begin
          cmd_r <= sw_wdata;
          st_r <= sel_ext ? ADCFG_LEAD : ADCFG_WAIT;
          if (sel_ext) guard_r <= 8'(EXT_GUARD);
        end
        ADCFG_LEAD: if (guard_r == 8'h00) st_r <= ADCFG_WAIT;
        ADCFG_WAIT: begin
          adr_r <= cmd_r[9:8];
          wd_r <= wd_fix;
          wr_r <= !cmd_r[CMD_RD];
          rd_r <= cmd_r[CMD_RD];
          if (!cmd_r[CMD_RD] && cmd_r[9:8] == ADR_SETUP_B)
            src_r <= cmd_r[B_CLKSRC];
          // keep the old clock alive after leaving it
          if (sel_int) guard_r <= 8'(EXT_GUARD);
          st_r <= ADCFG_IDLE;
        end
        default: st_r <= ADCFG_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // external clock and pins
  // ----------------------------------------------------------------
  logic ext_run; // clock must run now
  assign ext_run = clkrun_r | src_r | (guard_r != 8'h00) |
                   (st_r == ADCFG_LEAD);
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      half_r <= 4'h0;
      ext_r <= 1'b0;
    end else if (!ext_run && !ext_r) begin
      // a high phase always runs out, so a stop never cuts it short
      half_r <= 4'h0;
    end else if (half_r == 4'(EXT_HALF - 1)) begin
      half_r <= 4'h0;
      ext_r <= ~ext_r;
    end else begin
      half_r <= half_r + 4'h1;
    end
  end

  assign lnk.wr_stb = wr_r;
  assign lnk.rd_stb = rd_r;
  assign lnk.addr = adr_r;
  assign lnk.wdata = wd_r;
  assign lnk.ext_clk = ext_r;
  assign lnk.start_pin = pins_r[0];
  assign lnk.reset_pin = pins_r[1];
endmodule : adcfg_host

// [bench/adcfg_assertions.sv]
// adcfg_assertions: link checks between host and device ends.
// assumes one clk_sys and the interface signals wired in by name.
`timescale 1ns/1ps
module adcfg_assertions
  import adcfg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic ext_clk,
  input wire logic start_pin,
  input wire logic reset_pin
);
  // ------------------------------------------------------------
  // shadow of setup_reg_b as written on the wire
  // ------------------------------------------------------------
  logic [7:0] b_r; // last value written to setup_reg_b
  wire b_wr = wr_stb && addr == ADR_SETUP_B;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      b_r <= RST_SETUP_B;
    end else if (b_wr) begin
      b_r <= wdata;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  a_strobe_exclusive: assert property (!(wr_stb && rd_stb))
    else $error("both strobes high");
  a_write_spacing: assert property
    (wr_stb |=> (!wr_stb && !rd_stb)[*2])
    else $error("strobe too soon after write");
  a_read_spacing: assert property (rd_stb |=> !rd_stb && !wr_stb)
    else $error("strobe too soon after read");
  a_rdata_idle_zero: assert property (!rd_stb |=> rdata == 8'h00)
    else $error("read data outside its cycle");
  a_setup_b_readback: assert property
    (rd_stb && addr == ADR_SETUP_B |=> rdata == b_r)
    else $error("setup_reg_b readback differs");
  a_ext_half_period: assert property
    ($changed(ext_clk) |=> $stable(ext_clk))
    else $error("external clock half period short");
  a_select_lead: assert property
    (b_wr && wdata[B_CLKSRC] && !b_r[B_CLKSRC] |->
     ext_clk != $past(ext_clk, 2))
    else $error("external clock not running at select");
  a_leave_guard: assert property
    (b_wr && !wdata[B_CLKSRC] && b_r[B_CLKSRC] |=>
     (ext_clk != $past(ext_clk, 2))[*8])
    else $error("external clock stopped after leaving");
  // main scenarios reached
  c_select_ext: cover property (b_wr && wdata[B_CLKSRC]);
  c_leave_ext: cover property (b_wr && !wdata[B_CLKSRC] && b_r[B_CLKSRC]);
  c_status_rd: cover property (rd_stb && addr == ADR_STATUS);
endmodule : adcfg_assertions

// [bench/tb_adc_clock_and_range_config.sv]
// tb_adc_clock_and_range_config: host and device joined by the link.
// assumes a 40 MHz clk_sys; lockout shortened to LK cycles.
`timescale 1ns/1ps
module tb_adc_clock_and_range_config;
  import adcfg_pkg::*;
  localparam int LK = 20; // short lockout keeps the run brief
  logic clk_sys = 0, rst = 1, sw_wr = 0, sw_rd = 0, irq, sat_event = 0;
  logic conv_stb = 0, core_clk, mod_clk, span_2x, code_valid, pe = 0;
  logic start_ok, reset_ok, ref_bypass, lockout, rd_d = 0, cp = 0, mp = 0;
  logic [2:0] sw_addr = 0;
  logic [15:0] sw_wdata = 0, sw_rdata, code;
  logic signed [17:0] conv_raw = 0, r;
  logic [15:0] rq[$], cq[$]; // expected read data and codes
  int miscompares = 0, check_count = 0, nstart = 0, nlock = 0, nrs = 0, i;
  int cc = 0, mc = 0, cper = 0, mper = 0;
  adcfg_if lnk_if();
  adcfg_device #(.LOCK_CYC(LK)) adcfg_device_inst (.clk_sys(clk_sys),
    .rst(rst), .lnk(lnk_if), .sat_event(sat_event), .conv_stb(conv_stb),
    .conv_raw(conv_raw), .core_clk(core_clk), .mod_clk(mod_clk),
    .ref_bypass(ref_bypass), .span_2x(span_2x), .code(code),
    .code_valid(code_valid), .start_ok(start_ok), .reset_ok(reset_ok),
    .lockout(lockout));
  adcfg_host adcfg_host_inst (.clk_sys(clk_sys), .rst(rst), .lnk(lnk_if),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
    .sw_rdata(sw_rdata), .irq(irq));
  adcfg_assertions adcfg_assertions_inst (.clk_sys(clk_sys), .rst(rst),
    .wr_stb(lnk_if.wr_stb), .rd_stb(lnk_if.rd_stb), .addr(lnk_if.addr),
    .wdata(lnk_if.wdata), .rdata(lnk_if.rdata), .ext_clk(lnk_if.ext_clk),
    .start_pin(lnk_if.start_pin), .reset_pin(lnk_if.reset_pin));
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task report_and_stop();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  // one software access; a read queues its expected data
  task sw(input logic w, input logic [2:0] a, input logic [15:0] d);
    sw_addr <= a;
    sw_wdata <= d;
    if (w) sw_wr <= 1'h1;
    else begin
      sw_rd <= 1'h1;
      rq.push_back(d);
    end
    @(posedge clk_sys);
    sw_wr <= 1'h0;
    sw_rd <= 1'h0;
    @(posedge clk_sys);
  endtask : sw
  // link command, done when irq rises; status read clears it
  task cmd(input logic [1:0] a, input logic [7:0] d, input logic rd);
    int k;
    sw(1'h1, H_CMD, {3'h0, rd, 2'h0, a, d});
    for (k = 0; k < 100 && irq !== 1'h1; k++) @(posedge clk_sys);
    if (k == 100) begin
      miscompares++;
      report_and_stop();
    end
    sw(1'h0, H_STATUS, rd ? 16'h0002 : 16'h0001);
    repeat (3) @(posedge clk_sys);
  endtask : cmd
  task conv(input logic signed [17:0] v, input logic [15:0] e);
    conv_raw <= v;
    conv_stb <= 1'h1;
    cq.push_back(e);
    @(posedge clk_sys);
    conv_stb <= 1'h0;
    @(posedge clk_sys);
  endtask : conv
  task per(input int e);
    repeat (400) @(posedge clk_sys);
    chk(cper, e);
    chk(mper, 2 * e);
  endtask : per
  function logic [15:0] ex(input logic signed [17:0] v, input logic u);
    logic signed [17:0] t;
    t = u ? v : (v >>> 1);
    if (u) return (t < 0) ? 16'h0000 : (t > 18'sh0FFFF) ? 16'hFFFF : t[15:0];
    return (t > 18'sh07FFF) ? 16'h7FFF : (t < -18'sh08000) ? 16'h8000 : t[15:0];
  endfunction : ex
  // watcher: read data, codes, pin events and clock periods
  always @(posedge clk_sys) begin
    if (rd_d) chk(sw_rdata, rq.pop_front());
    if (code_valid) chk(code, cq.pop_front());
    rd_d <= sw_rd;
    if (pe) chk(ref_bypass, mp & ~cp);
    nstart <= nstart + start_ok;
    nrs <= nrs + reset_ok;
    nlock <= nlock + lockout;
    cp <= core_clk;
    mp <= mod_clk;
    cc <= (core_clk && !cp) ? 0 : cc + 1;
    mc <= (mod_clk && !mp) ? 0 : mc + 1;
    if (core_clk && !cp) cper <= cc + 1;
    if (mod_clk && !mp) mper <= mc + 1;
  end
  initial begin
    void'($urandom(32'hDF17));
    repeat (3) @(posedge clk_sys);
    rst <= 1'h0;
    @(posedge clk_sys);
    sw(1'h0, H_STATUS, 16'h0000);
    sw(1'h1, H_MASK, 16'h0003);
    cmd(ADR_SETUP_B, 8'h00, 1'h1);
    sw(1'h0, H_RDDATA, 16'h0008);
    $display("test reset done");
    cmd(ADR_SETUP_A, 8'h01, 1'h0);
    chk(span_2x, 1);
    sw(1'h1, H_VREF, 16'h1000);
    cmd(ADR_SETUP_A, 8'h05, 1'h0);
    pe <= 1'h1;
    chk(span_2x, 0);
    sw(1'h1, H_MASK, 16'h0000);
    sw(1'h1, H_CMD, 16'h0300);
    repeat (30) @(posedge clk_sys);
    chk(irq, 0);
    sw(1'h0, H_STATUS, 16'h0001);
    sw(1'h1, H_MASK, 16'h0003);
    $display("test span done");
    for (i = 0; i < 12; i++) begin
      if (i == 6) cmd(ADR_SETUP_D, 8'h01, 1'h0);
      r = (i % 6 == 0) ? 18'h1FFFF : (i % 6 == 1) ? 18'h20000 : 18'($urandom);
      conv(r, ex(r, i >= 6));
    end
    cmd(ADR_SETUP_B, 8'h09, 1'h0);
    conv(18'h05000, 16'h4000);
    cmd(ADR_SETUP_B, 8'h08, 1'h0);
    $display("test codes done");
    sat_event <= 1'h1;
    @(posedge clk_sys);
    sat_event <= 1'h0;
    cmd(ADR_STATUS, 8'h00, 1'h1);
    sw(1'h0, H_RDDATA, 16'h0001);
    cmd(ADR_STATUS, 8'h00, 1'h1);
    sw(1'h0, H_RDDATA, 16'h0000);
    $display("test saturation done");
    per(2);
    cmd(ADR_SETUP_B, 8'h00, 1'h0);
    per(16);
    sw(1'h1, H_CLKCTL, 16'h0001);
    cmd(ADR_SETUP_B, 8'h0A, 1'h0);
    sw(1'h1, H_PINS, 16'h0003);
    per(8);
    cmd(ADR_SETUP_B, 8'h0E, 1'h0);
    per(64);
    sw(1'h1, H_CLKCTL, 16'h0000);
    cmd(ADR_SETUP_B, 8'h08, 1'h0);
    repeat (LK) @(posedge clk_sys);
    sw(1'h1, H_PINS, 16'h0000);
    sw(1'h1, H_PINS, 16'h0001);
    sw(1'h1, H_PINS, 16'h0003);
    repeat (5) @(posedge clk_sys);
    chk(nstart, 1);
    chk(nrs, 1);
    chk(nlock, 2 * LK);
    $display("test clocks done");
    report_and_stop();
  end
endmodule : tb_adc_clock_and_range_config
